// ==== rtl/ddc_pkg.sv ====
// Package for the two-channel converter control block: register map, reset values, field positions, timing.
// Assumes a single 40 MHz clock domain and a plain address/strobe register port.
`default_nettype none
package ddc_pkg;

  // Register indices; the printed map uses byte addresses that are not word aligned, so a small index is used.
  localparam logic [1:0] ADDR_CH0_CODE  = 2'h0;
  localparam logic [1:0] ADDR_CH1_CODE  = 2'h1;
  localparam logic [1:0] ADDR_CTRL      = 2'h2;
  localparam logic [1:0] ADDR_STBY_CTRL = 2'h3;

  // Reset values.
  localparam logic [7:0] RST_CODE      = 8'h00;
  localparam logic [7:0] RST_CTRL      = 8'h1F;
  localparam logic [7:0] RST_STBY_CTRL = 8'hFE;

  // Field positions.
  localparam int BIT_CH1_OE  = 7;
  localparam int BIT_CH0_OE  = 6;
  localparam int BIT_JOINT   = 5;
  localparam int BIT_KEEP    = 0;
  localparam logic [7:0] CTRL_RSVD_MASK = 8'h1F;
  localparam logic [7:0] STBY_RSVD_MASK = 8'hFE;

  // Settling time of a conversion: 10 us at 40 MHz, longest time rounded down.
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SETTLE_TIME_NS = 10000;
  localparam int SETTLE_CYCLES  = SETTLE_TIME_NS / CLK_PERIOD_NS;
  localparam int SETTLE_W       = 9;

  // One register-port access.
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ddc_bus_s;

  // Per-channel converter state.
  typedef enum logic [1:0] {CH_IDLE, CH_SETTLE, CH_VALID} ddc_ch_e;

endpackage
`default_nettype wire

// ==== rtl/ddc_top.sv ====
// Control logic for a two-channel 8-bit converter: code, control and standby registers and per-channel sequencing.
// Assumes synchronous inputs on REF_CLK_I, an external analog core fed from CODE_CHn_O, and standby
// requests from the chip's power controller.
//
// Overview of operation
// - Each channel has an 8-bit readable and writable code register.
// - Code registers clear to zero at reset and on standby entry.
// - Control register resets to 0x1F at reset and standby entry.
// - Control bit 7 enables channel 1 conversion and output.
// - Control bit 6 enables channel 0 conversion and output.
// - Bit 5 clear: own enable only; set: both convert if either enabled.
// - Both output enables clear disables conversion in both channels.
// - Pin drive follows only the channel's own output enable.
// - Control bits 4 to 0 are read-only and read as ones.
// - Standby register resets to 0xFE, held through software standby.
// - Standby register bits 7 to 1 are read-only ones.
// - Standby bit 0 set keeps output active in software standby.
// - Enabled channel converts continuously; code change restarts conversion at once.
// - Output level is code over 256 times reference, held until change.
// - Clearing output enable releases the pin to input.
// - With standby output kept, registers retain their values through software standby.
// - Conversion runs without a software start trigger.
// - Result valid within 10 us of conversion start.
//
// A rising software standby request clears codes and control unless the keep bit is set.
// Hardware standby is a level and clears every register, the keep bit included, while it lasts.
// The settle counter stands in for the analog conversion time; any code change restarts it.
// A low clock enable freezes every register, so strobes seen while it is low are lost.
// Reserved control bits are not stored at all, which makes ignoring their writes automatic.
// Read data are registered and hold until the next read strobe, so a stale read stays visible.
// The analog pin itself lives outside; this block only says when it drives and what code it shows.
`default_nettype none
module ddc_top
  import ddc_pkg::*;
(
  input  wire logic       REF_CLK_I,
  input  wire logic       RSTN_I,
  input  wire logic       CLK_EN_I,
  input  wire logic [1:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  input  wire logic       SW_STANDBY_I,
  input  wire logic       HW_STANDBY_I,
  output logic      [7:0] RDATA_O,
  output logic      [7:0] CODE_CH0_O,
  output logic      [7:0] CODE_CH1_O,
  output logic            CONV_CH0_O,
  output logic            CONV_CH1_O,
  output logic            OE_CH0_O,
  output logic            OE_CH1_O,
  output logic            VALID_CH0_O,
  output logic            VALID_CH1_O
);
  import ddc_pkg::*;

  // Bundle the port into the carrier struct.
  ddc_bus_s bus;
  assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  logic [7:0] code0_q;
  logic [7:0] code0_d;
  logic [7:0] code1_q;
  logic [7:0] code1_d;
  logic [2:0] ctrl_q;                    // Only the writable bits 7..5 are stored.
  logic [2:0] ctrl_d;
  logic       keep_q;
  logic       keep_d;
  logic       sw_stby_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Address decode.
  wire wr_code0 = bus.wr && bus.addr == ADDR_CH0_CODE;
  wire wr_code1 = bus.wr && bus.addr == ADDR_CH1_CODE;
  wire wr_ctrl  = bus.wr && bus.addr == ADDR_CTRL;
  wire wr_stby  = bus.wr && bus.addr == ADDR_STBY_CTRL;

  // Standby entry clears codes and control unless the keep bit holds them; hardware standby always clears.
  wire sw_entry   = SW_STANDBY_I && !sw_stby_q;
  wire clr_regs   = HW_STANDBY_I || (sw_entry && !keep_q);

  // Architectural views of the control registers; reserved bits always read as ones.
  wire [7:0] ctrl_view = {ctrl_q, 5'h1F} | CTRL_RSVD_MASK;
  wire [7:0] stby_view = {7'h7F, keep_q} | STBY_RSVD_MASK;
  wire ch1_oe = ctrl_q[BIT_CH1_OE - 5];
  wire ch0_oe = ctrl_q[BIT_CH0_OE - 5];
  wire joint  = ctrl_q[BIT_JOINT - 5];

  // In software standby the outputs stay alive only if the keep bit is set.
  wire active = !HW_STANDBY_I && (!SW_STANDBY_I || keep_q);

  // Conversion enables; with no output enable set nothing converts, whatever the joint bit.
  wire any_oe = ch0_oe || ch1_oe;
  wire conv0  = active && (joint ? any_oe : ch0_oe);
  wire conv1  = active && (joint ? any_oe : ch1_oe);
  // Pin drive ignores the joint bit.
  wire drive0 = active && ch0_oe;
  wire drive1 = active && ch1_oe;

  // Next values of the software registers; reserved bits of a write are dropped.
  assign code0_d = clr_regs ? RST_CODE : (wr_code0 ? bus.wdata : code0_q);
  assign code1_d = clr_regs ? RST_CODE : (wr_code1 ? bus.wdata : code1_q);
  assign ctrl_d  = clr_regs ? RST_CTRL[7:5] : (wr_ctrl ? bus.wdata[7:5] : ctrl_q);
  assign keep_d  = HW_STANDBY_I ? RST_STBY_CTRL[BIT_KEEP]
                 : (wr_stby ? bus.wdata[BIT_KEEP] : keep_q);

  // Read mux; an unused address cannot occur with a two-bit index.
  always_comb begin
    unique case (bus.addr)
      ADDR_CH0_CODE: rdata_d = code0_q;
      ADDR_CH1_CODE: rdata_d = code1_q;
      ADDR_CTRL:     rdata_d = ctrl_view;
      ADDR_STBY_CTRL: rdata_d = stby_view;
    endcase
  end

  // Register file and read data; read data only changes on a read strobe.
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      code0_q   <= RST_CODE;
      code1_q   <= RST_CODE;
      ctrl_q    <= RST_CTRL[7:5];
      keep_q    <= RST_STBY_CTRL[BIT_KEEP];
      sw_stby_q <= 1'b0;
      rdata_q   <= 8'h00;
    end else if (CLK_EN_I) begin
      code0_q   <= code0_d;
      code1_q   <= code1_d;
      ctrl_q    <= ctrl_d;
      keep_q    <= keep_d;
      sw_stby_q <= SW_STANDBY_I;
      if (bus.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Per-channel settle sequencer, shared by both channels through a function.
  function automatic ddc_ch_e ch_next(input ddc_ch_e st, input logic en, input logic chg,
                                      input logic [SETTLE_W-1:0] cnt);
    ch_next = st;
    unique case (st)
      CH_IDLE: begin
        if (en) begin
          ch_next = CH_SETTLE;
        end
      end
      CH_SETTLE: begin
        if (!en) begin
          ch_next = CH_IDLE;
        end else if (!chg && cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
          ch_next = CH_VALID;
        end
      end
      CH_VALID: begin
        if (!en) begin
          ch_next = CH_IDLE;
        end else if (chg) begin
          ch_next = CH_SETTLE;
        end
      end
      // The fourth code of the two-bit state is illegal; fall back to idle.
      default: begin
        ch_next = CH_IDLE;
      end
    endcase
  endfunction

  ddc_ch_e st0_q, st0_d, st1_q, st1_d;
  logic [SETTLE_W-1:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d;

  // A code change restarts the settle count at once.
  wire chg0 = code0_d != code0_q;
  wire chg1 = code1_d != code1_q;
  assign st0_d  = ch_next(st0_q, conv0, chg0, cnt0_q);
  assign st1_d  = ch_next(st1_q, conv1, chg1, cnt1_q);
  // The count stays below the settle limit so valid comes within the bound.
  assign cnt0_d = (st0_d == CH_SETTLE && st0_q == CH_SETTLE && !chg0) ? cnt0_q + 1'b1 : '0;
  assign cnt1_d = (st1_d == CH_SETTLE && st1_q == CH_SETTLE && !chg1) ? cnt1_q + 1'b1 : '0;

  // Sequencer state and output registers; the analog core converts whatever code it sees.
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      st0_q       <= CH_IDLE;
      st1_q       <= CH_IDLE;
      cnt0_q      <= '0;
      cnt1_q      <= '0;
      CODE_CH0_O  <= 8'h00;
      CODE_CH1_O  <= 8'h00;
      CONV_CH0_O  <= 1'b0;
      CONV_CH1_O  <= 1'b0;
      OE_CH0_O    <= 1'b0;
      OE_CH1_O    <= 1'b0;
      VALID_CH0_O <= 1'b0;
      VALID_CH1_O <= 1'b0;
    end else if (CLK_EN_I) begin
      st0_q       <= st0_d;
      st1_q       <= st1_d;
      cnt0_q      <= cnt0_d;
      cnt1_q      <= cnt1_d;
      CODE_CH0_O  <= code0_d;
      CODE_CH1_O  <= code1_d;
      CONV_CH0_O  <= conv0;
      CONV_CH1_O  <= conv1;
      OE_CH0_O    <= drive0;
      OE_CH1_O    <= drive1;
      VALID_CH0_O <= st0_d == CH_VALID && drive0;
      VALID_CH1_O <= st1_d == CH_VALID && drive1;
    end
  end

  assign RDATA_O = rdata_q;

  // Checks on the design's own behaviour.
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  a_ctrl_rsvd_ones: assert property (bus.rd && bus.addr == ADDR_CTRL && CLK_EN_I |=> RDATA_O[4:0] == 5'h1F)
    else $error("control reserved bits not ones");
  a_stby_rsvd_ones: assert property (bus.rd && bus.addr == ADDR_STBY_CTRL && CLK_EN_I |=> RDATA_O[7:1] == 7'h7F)
    else $error("standby reserved bits not ones");
  a_code_readback: assert property (wr_code0 && !clr_regs && CLK_EN_I ##1 bus.rd && bus.addr == ADDR_CH0_CODE && CLK_EN_I
                                    |=> RDATA_O == $past(bus.wdata, 2))
    else $error("code readback mismatch");
  a_hw_stby_clear: assert property (HW_STANDBY_I && CLK_EN_I |=> code0_q == 8'h00 && code1_q == 8'h00 && ctrl_view == 8'h1F)
    else $error("hardware standby did not clear");
  a_stby_hold_keep: assert property (sw_entry && keep_q && !HW_STANDBY_I && !bus.wr && CLK_EN_I |=> $stable(code0_q))
    else $error("code lost in kept standby");
  a_no_oe_no_conv: assert property (!ch0_oe && !ch1_oe && CLK_EN_I |=> !CONV_CH0_O && !CONV_CH1_O)
    else $error("conversion without enable");
  a_joint_both: assert property (active && joint && any_oe && CLK_EN_I |=> CONV_CH0_O && CONV_CH1_O)
    else $error("joint conversion missing");
  a_drive_own_oe: assert property (active && CLK_EN_I |=> OE_CH0_O == $past(ch0_oe) && OE_CH1_O == $past(ch1_oe))
    else $error("pin drive not own enable");
  a_settle_bound: assert property (st0_q == CH_SETTLE && conv0 && !chg0 && cnt0_q == 9'd0 && CLK_EN_I
                                   ##1 (conv0 && !chg0 && CLK_EN_I)[*8] |-> st0_q == CH_SETTLE)
    else $error("settle ended early");

  // A low clock enable must freeze the software registers.
  a_clk_en_freeze: assert property (!CLK_EN_I |=> $stable(code0_q) && $stable(code1_q) && $stable(ctrl_q))
    else $error("registers moved with clock enable low");

  // A low clock enable must freeze the outputs too.
  a_freeze_outputs: assert property (!CLK_EN_I |=> $stable(RDATA_O) && $stable(OE_CH0_O) && $stable(VALID_CH0_O))
    else $error("outputs moved with clock enable low");

  // Unkept software standby entry clears codes and control.
  a_sw_entry_clear: assert property (sw_entry && !keep_q && CLK_EN_I
                                     |=> code0_q == 8'h00 && code1_q == 8'h00 && ctrl_view == 8'h1F)
    else $error("standby entry did not clear");

  // Hardware standby clears the keep bit.
  a_keep_hw_clear: assert property (HW_STANDBY_I && CLK_EN_I |=> !keep_q)
    else $error("keep bit survived hardware standby");

  // Software standby leaves the keep bit alone.
  a_keep_sw_hold: assert property (SW_STANDBY_I && !HW_STANDBY_I && !wr_stby && CLK_EN_I |=> keep_q == $past(keep_q))
    else $error("keep bit lost in software standby");

  // A control write lands in the stored bits.
  a_ctrl_write_lands: assert property (wr_ctrl && !clr_regs && CLK_EN_I |=> ctrl_q == $past(bus.wdata[7:5]))
    else $error("control write lost");

  // Without the joint bit channel 0 follows its own enable.
  a_ch0_conv_own: assert property (active && !joint && CLK_EN_I |=> CONV_CH0_O == $past(ch0_oe))
    else $error("channel 0 conversion not own enable");

  // Without the joint bit channel 1 follows its own enable.
  a_ch1_conv_own: assert property (active && !joint && CLK_EN_I |=> CONV_CH1_O == $past(ch1_oe))
    else $error("channel 1 conversion not own enable");

  // Unkept software standby stops everything.
  a_stby_drop_all: assert property (SW_STANDBY_I && !keep_q && CLK_EN_I
                                    |=> !CONV_CH0_O && !CONV_CH1_O && !OE_CH0_O && !OE_CH1_O)
    else $error("output alive in unkept standby");

  // Kept software standby keeps the pin driving.
  a_stby_keep_drive: assert property (SW_STANDBY_I && keep_q && !HW_STANDBY_I && ch0_oe && CLK_EN_I |=> OE_CH0_O)
    else $error("pin dropped in kept standby");

  // Hardware standby stops everything.
  a_hw_no_drive: assert property (HW_STANDBY_I && CLK_EN_I
                                  |=> !OE_CH0_O && !OE_CH1_O && !CONV_CH0_O && !CONV_CH1_O)
    else $error("output alive in hardware standby");

  // A cleared enable releases the channel 0 pin.
  a_ch0_release: assert property (!ch0_oe && CLK_EN_I |=> !OE_CH0_O && !VALID_CH0_O)
    else $error("channel 0 pin not released");

  // A cleared enable releases the channel 1 pin.
  a_ch1_release: assert property (!ch1_oe && CLK_EN_I |=> !OE_CH1_O && !VALID_CH1_O)
    else $error("channel 1 pin not released");

  // A settled channel 0 result implies conversion and drive.
  a_ch0_valid_conv: assert property (VALID_CH0_O |-> CONV_CH0_O && OE_CH0_O)
    else $error("channel 0 valid without conversion");

  // A settled channel 1 result implies conversion and drive.
  a_ch1_valid_conv: assert property (VALID_CH1_O |-> CONV_CH1_O && OE_CH1_O)
    else $error("channel 1 valid without conversion");

  // A channel 0 code change drops valid and restarts the count.
  a_ch0_restart: assert property (chg0 && CLK_EN_I |=> !VALID_CH0_O && cnt0_q == 9'd0)
    else $error("channel 0 did not restart");

  // A channel 1 code change drops valid and restarts the count.
  a_ch1_restart: assert property (chg1 && CLK_EN_I |=> !VALID_CH1_O && cnt1_q == 9'd0)
    else $error("channel 1 did not restart");

  // Channel 0 goes idle as soon as conversion is off.
  a_ch0_idle_clear: assert property (!conv0 && CLK_EN_I |=> !VALID_CH0_O && st0_q == CH_IDLE)
    else $error("channel 0 not idle");

  // Channel 1 goes idle as soon as conversion is off.
  a_ch1_idle_clear: assert property (!conv1 && CLK_EN_I |=> !VALID_CH1_O && st1_q == CH_IDLE)
    else $error("channel 1 not idle");

  // The code seen by the channel 0 core mirrors its register.
  a_ch0_code_out: assert property (CLK_EN_I |=> CODE_CH0_O == code0_q)
    else $error("channel 0 code out of step");

  // The code seen by the channel 1 core mirrors its register.
  a_ch1_code_out: assert property (CLK_EN_I |=> CODE_CH1_O == code1_q)
    else $error("channel 1 code out of step");

  // Read data hold between read strobes.
  a_rdata_hold: assert property (!bus.rd && CLK_EN_I |=> $stable(RDATA_O))
    else $error("read data moved without a read");

  // Channel 1 settling does not end early either.
  a_ch1_settle_bound: assert property (st1_q == CH_SETTLE && conv1 && !chg1 && cnt1_q == 9'd0 && CLK_EN_I
                                       ##1 (conv1 && !chg1 && CLK_EN_I)[*8] |-> st1_q == CH_SETTLE)
    else $error("channel 1 settle ended early");

  // Channel 0 settles once the count reaches its limit.
  a_ch0_valid_in_time: assert property (st0_q == CH_SETTLE && cnt0_q == SETTLE_W'(SETTLE_CYCLES - 1)
                                        && conv0 && !chg0 && CLK_EN_I |=> st0_q == CH_VALID)
    else $error("channel 0 settled late");

  // Channel 1 settles once the count reaches its limit.
  a_ch1_valid_in_time: assert property (st1_q == CH_SETTLE && cnt1_q == SETTLE_W'(SETTLE_CYCLES - 1)
                                        && conv1 && !chg1 && CLK_EN_I |=> st1_q == CH_VALID)
    else $error("channel 1 settled late");

  c_hw_stby:    cover property (HW_STANDBY_I && CLK_EN_I);
  c_ch0_valid:  cover property (VALID_CH0_O);
  c_joint_conv: cover property (joint && CONV_CH0_O && CONV_CH1_O);
  c_kept_stby:  cover property (SW_STANDBY_I && keep_q && OE_CH0_O);
  c_restart:    cover property (st0_q == CH_VALID && chg0);

endmodule
`default_nettype wire

// ==== verif/ddc_top_bench.sv ====
// Self-checking bench for the two-channel converter control block: registers, enables, settling, standby.
// Assumes ddc_pkg and ddc_top are compiled first; the bench drives every port of the block itself.
`default_nettype none
module ddc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ddc_pkg::*;

  logic       clk, rst_n, clk_en, wr_s, rd_s, sw_stby, hw_stby;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, code0, code1;
  logic       conv0, conv1, oe0, oe1, val0, val1;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         n;
  // Enables seen at the pins, packed as conversion 1, conversion 0, drive 1, drive 0.
  wire logic [3:0] ctl = {conv1, conv0, oe1, oe0};

  // Control writes with the enables they must give; reserved bits are written as zeros.
  typedef struct packed {logic [7:0] d; logic [3:0] e;} ddc_row_s;
  localparam ddc_row_s ROWS [8] = '{'{8'h00, 4'h0}, '{8'h20, 4'h0}, '{8'h40, 4'h5}, '{8'h60, 4'hD},
                                    '{8'h80, 4'hA}, '{8'hA0, 4'hE}, '{8'hC0, 4'hF}, '{8'hE0, 4'hF}};

  ddc_top i_dut (.REF_CLK_I(clk), .RSTN_I(rst_n), .CLK_EN_I(clk_en), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_s), .RD_I(rd_s), .SW_STANDBY_I(sw_stby), .HW_STANDBY_I(hw_stby), .RDATA_O(rdata),
    .CODE_CH0_O(code0), .CODE_CH1_O(code1), .CONV_CH0_O(conv0), .CONV_CH1_O(conv1),
    .OE_CH0_O(oe0), .OE_CH1_O(oe1), .VALID_CH0_O(val0), .VALID_CH1_O(val1));

  // A half period of 12.5 ns gives the 40 MHz reference clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Waits whole cycles, then steps past the edge so registered outputs have settled.
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask

  // Read data load on the edge that takes the strobe and hold until the next read strobe; they are sampled just past that edge.
  task automatic reg_rd(input logic [1:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    addr <= a; rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask

  // Counts cycles until channel 0 reports a settled result; a stuck flag ends the run.
  task automatic wait_valid(output int c);
    c = 0;
    while (val0 !== 1'b1 && c < 1000) begin
      tick(1);
      c++;
    end
    if (c >= 1000) begin
      n_errors++;
      $display("wrong value valid0 expected 1 seen timeout");
      test_done();
    end
  endtask

  // Cuts a hung run short well inside the cycle budget.
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    test_done();
  end

  initial begin
    rst_n = 1'b0; clk_en = 1'b1; wr_s = 1'b0; rd_s = 1'b0; sw_stby = 1'b0; hw_stby = 1'b0;
    addr = 2'h0; wdata = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(ADDR_CH0_CODE, RST_CODE, "code0");
    reg_rd(ADDR_CH1_CODE, RST_CODE, "code1");
    reg_rd(ADDR_CTRL, RST_CTRL, "ctrl");
    reg_rd(ADDR_STBY_CTRL, RST_STBY_CTRL, "stby");
    chk("enables", {4'h0, ctl}, 8'h00);
    reg_wr(ADDR_CH0_CODE, 8'hA5);
    reg_wr(ADDR_CH1_CODE, 8'h5A);
    reg_rd(ADDR_CH0_CODE, 8'hA5, "code0");
    reg_rd(ADDR_CH1_CODE, 8'h5A, "code1");
    chk("code0 out", code0, 8'hA5);
    chk("code1 out", code1, 8'h5A);
    foreach (ROWS[i]) begin
      reg_wr(ADDR_CTRL, ROWS[i].d);
      tick(2);
      chk("enables", {4'h0, ctl}, {4'h0, ROWS[i].e});
      reg_rd(ADDR_CTRL, ROWS[i].d | CTRL_RSVD_MASK, "ctrl");
    end
    reg_wr(ADDR_STBY_CTRL, 8'h00);
    reg_rd(ADDR_STBY_CTRL, 8'hFE, "stby");
    reg_wr(ADDR_STBY_CTRL, 8'h01);
    reg_rd(ADDR_STBY_CTRL, 8'hFF, "stby");
    reg_wr(ADDR_STBY_CTRL, 8'h00);
    // Settling from a fresh enable, then a restart caused by a code change.
    reg_wr(ADDR_CTRL, 8'h00);
    tick(2);
    reg_wr(ADDR_CTRL, 8'h40);
    wait_valid(n);
    chk("settle time", {7'h0, 1'(n <= SETTLE_CYCLES + 3)}, 8'h01);
    chk("valid1", {7'h0, val1}, 8'h00);
    reg_wr(ADDR_CH0_CODE, 8'h3C);
    tick(1);
    chk("valid0", {7'h0, val0}, 8'h00);
    wait_valid(n);
    chk("resettle time", {7'h0, 1'(n <= SETTLE_CYCLES + 3)}, 8'h01);
    chk("code0 out", code0, 8'h3C);
    // Software standby without the keep bit drops the outputs and clears codes and control.
    reg_wr(ADDR_CTRL, 8'hC0);
    @(posedge clk) sw_stby <= 1'b1;
    tick(3);
    chk("enables", {4'h0, ctl}, 8'h00);
    @(posedge clk) sw_stby <= 1'b0;
    tick(2);
    reg_rd(ADDR_CH0_CODE, RST_CODE, "code0");
    reg_rd(ADDR_CTRL, RST_CTRL, "ctrl");
    reg_rd(ADDR_STBY_CTRL, RST_STBY_CTRL, "stby");
    // With the keep bit set everything survives software standby and the pins keep driving.
    reg_wr(ADDR_STBY_CTRL, 8'h01);
    reg_wr(ADDR_CTRL, 8'hC0);
    reg_wr(ADDR_CH1_CODE, 8'h77);
    @(posedge clk) sw_stby <= 1'b1;
    tick(3);
    chk("enables", {4'h0, ctl}, 8'h0F);
    @(posedge clk) sw_stby <= 1'b0;
    tick(2);
    reg_rd(ADDR_CH1_CODE, 8'h77, "code1");
    reg_rd(ADDR_CTRL, 8'hDF, "ctrl");
    reg_rd(ADDR_STBY_CTRL, 8'hFF, "stby");
    // Hardware standby clears every register, the keep bit included.
    @(posedge clk) hw_stby <= 1'b1;
    tick(2);
    @(posedge clk) hw_stby <= 1'b0;
    tick(1);
    reg_rd(ADDR_STBY_CTRL, RST_STBY_CTRL, "stby");
    reg_rd(ADDR_CH1_CODE, RST_CODE, "code1");
    reg_rd(ADDR_CTRL, RST_CTRL, "ctrl");
    // A write while the clock enable is low must be lost.
    @(posedge clk) clk_en <= 1'b0;
    reg_wr(ADDR_CH0_CODE, 8'h99);
    @(posedge clk) clk_en <= 1'b1;
    reg_rd(ADDR_CH0_CODE, RST_CODE, "code0 frozen");
    // A reset in mid-run clears the registers and drops the enables.
    reg_wr(ADDR_CTRL, 8'h40);
    reg_wr(ADDR_CH0_CODE, 8'h12);
    @(posedge clk) rst_n <= 1'b0;
    tick(2);
    chk("enables", {4'h0, ctl}, 8'h00);
    chk("code0 out", code0, RST_CODE);
    @(posedge clk) rst_n <= 1'b1;
    reg_rd(ADDR_CH0_CODE, RST_CODE, "code0");
    reg_rd(ADDR_CTRL, RST_CTRL, "ctrl");
    test_done();
  end
endmodule
`default_nettype wire
